// *** common/exec_pkg.sv ***
// shared constants and types for the rotate / subtract / sleep execution block
package exec_pkg;

    // ==========================================================
    // register byte offsets (12-bit bus address space)
    localparam logic [11:0] OFF_INSTR     = 12'h000;
    localparam logic [11:0] OFF_ACC       = 12'h004;
    localparam logic [11:0] OFF_STATUS    = 12'h008;
    localparam logic [11:0] OFF_WATCHDOG  = 12'h00c;
    localparam logic [11:0] OFF_FILE_BASE = 12'h100;
    localparam logic [11:0] OFF_FILE_LAST = 12'h2fc;

    // ==========================================================
    // instruction register fields
    localparam int INSTR_OP_LSB    = 0;
    localparam int INSTR_DEST_BIT  = 2;
    localparam int INSTR_FADDR_LSB = 8;
    localparam int INSTR_LIT_LSB   = 16;

    // ==========================================================
    // status register bit positions
    localparam int ST_CARRY     = 0;
    localparam int ST_NIBBLE    = 1;
    localparam int ST_ZERO      = 2;
    localparam int ST_TIMEOUT_N = 3;
    localparam int ST_PDOWN_N   = 4;
    localparam int ST_SLEEP     = 5;
    localparam int ST_BUSY      = 6;

    // ==========================================================
    // watchdog register fields
    localparam int WD_COUNT_LSB = 0;
    localparam int WD_PRE_LSB   = 8;

    // ==========================================================
    // reset values and bus answers
    localparam logic [7:0] ACC_RESET       = 8'h00;
    localparam logic       TIMEOUT_N_RESET = 1'b1;
    localparam logic       PDOWN_N_RESET   = 1'b1;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;

    // read pipeline stages
    localparam logic [1:0] RD_IDLE = 2'h0;
    localparam logic [1:0] RD_ADDR = 2'h1;
    localparam logic [1:0] RD_DATA = 2'h2;

    // ==========================================================
    // operations and sequencer states
    typedef enum logic [1:0] {
        rotate_left_carry_op  = 2'h0,
        rotate_right_carry_op = 2'h1,
        literal_minus_acc_op  = 2'h2,
        sleep_op              = 2'h3
    } opcode_t;

    typedef enum logic [3:0] {
        st_idle  = 4'h1,
        st_fetch = 4'h2,
        st_exec  = 4'h4,
        st_sleep = 4'h8
    } exec_state_t;

endpackage : exec_pkg

// *** common/file_mem_if.sv ***
// port bundle between the execution core and its file register memory
`timescale 1ns/1ps
interface file_mem_if;
    logic [6:0] raddr;
    logic [7:0] rdata;
    logic       we;
    logic [6:0] waddr;
    logic [7:0] wdata;

    modport ctrl (output raddr, output we, output waddr, output wdata, input rdata);
    modport mem  (input raddr, input we, input waddr, input wdata, output rdata);
endinterface : file_mem_if

// *** design/file_mem.sv ***
// 128 x 8 file register memory with registered read data
`timescale 1ns/1ps
module file_mem
    import exec_pkg::*;
(
    input wire logic   aclk,
    input wire logic   aresetn,
    file_mem_if.mem    port
);

    typedef struct packed {
        logic [127:0][7:0] cells;
        logic [7:0]        rdata;
    } mem_state_t;

    mem_state_t s;
    mem_state_t next_s;

    // ==========================================================
    // read returns the old word when read and write hit the same cell
    always_comb begin
        next_s = s;
        if (port.we) begin
            next_s.cells[port.waddr] = port.wdata;
        end
        next_s.rdata = s.cells[port.raddr];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign port.rdata = s.rdata;

endmodule : file_mem

// *** design/rot_sub_sleep_exec.sv ***
// execution unit for rotate-through-carry, literal subtract and sleep, with AXI4-Lite slave
// What this block does
// - left rotate: file operand shifts up, old carry to bit 0, bit 7 to carry
// - rotates: destination bit 0 writes accumulator, 1 writes file register back
// - right rotate: operand shifts down, old carry to bit 7, bit 0 to carry
// - sleep clears the active-low power-down flag
// - sleep sets the active-low time-out flag to one
// - sleep clears the watchdog counter and its prescaler
// - sleep halts the oscillator; execution stops until wake-up
// - literal subtract writes literal minus accumulator into accumulator
`timescale 1ns/1ps
module rot_sub_sleep_exec
    import exec_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output wire logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output wire logic        wready,
    output wire logic [1:0]  bresp,
    output wire logic        bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output wire logic        arready,
    output wire logic [31:0] rdata,
    output wire logic [1:0]  rresp,
    output wire logic        rvalid,
    input  wire logic        rready,
    input  wire logic        wake_req,
    output wire logic        osc_run
);

    // ==========================================================
    // state
    typedef struct packed {
        exec_state_t st;
        opcode_t     op;
        logic        dest;
        logic [6:0]  faddr;
        logic [7:0]  lit;
        logic [7:0]  acc;
        logic        carry;
        logic        nibble_carry_flag;
        logic        zero;
        logic        timeout_flag_n;
        logic        power_down_flag_n;
        logic [7:0]  watchdog_counter;
        logic [7:0]  wd_pre;
        logic        aw_hold;
        logic        w_hold;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic [1:0]  rd_stage;
        logic [11:0] araddr;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } core_t;

    core_t      s;
    core_t      next_s;
    file_mem_if mp ();

    logic       commit;
    logic       launch;
    opcode_t    launch_op;
    logic [7:0] fop;
    logic [7:0] rot_res;
    logic       rot_carry;
    logic [8:0] diff;

    default clocking cb @(posedge aclk); endclocking   // checks are disabled while reset is asserted
    default disable iff (!aresetn);

    // ==========================================================
    // address decode shared by write and read paths
    function automatic logic is_file(input logic [11:0] a);
        return (a[11:2] >= OFF_FILE_BASE[11:2]) && (a[11:2] <= OFF_FILE_LAST[11:2]);
    endfunction : is_file

    function automatic logic [6:0] file_index(input logic [11:0] a);
        return 7'((a - OFF_FILE_BASE) >> 2);
    endfunction : file_index

    file_mem u_mem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .port    (mp)
    );

    // ==========================================================
    // handshakes; writes are refused while an instruction runs or sleeps
    assign awready = !s.aw_hold && !s.bvalid && (s.st == st_idle);
    assign wready  = !s.w_hold && !s.bvalid && (s.st == st_idle);
    assign arready = (s.rd_stage == RD_IDLE) && !s.rvalid;
    assign bvalid  = s.bvalid;
    assign bresp   = s.bresp;
    assign rvalid  = s.rvalid;
    assign rdata   = s.rdata;
    assign rresp   = s.rresp;
    assign osc_run = (s.st != st_sleep);

    assign commit    = s.aw_hold && s.w_hold;
    assign launch    = commit && (s.awaddr[11:2] == OFF_INSTR[11:2]) && s.wstrb[0];
    assign launch_op = opcode_t'(s.wdata[INSTR_OP_LSB +: 2]);

    // ==========================================================
    // datapath: rotates through carry and literal minus accumulator
    assign fop       = mp.rdata;
    assign rot_res   = (s.op == rotate_left_carry_op) ? {fop[6:0], s.carry}
                                                      : {s.carry, fop[7:1]};
    assign rot_carry = (s.op == rotate_left_carry_op) ? fop[7] : fop[0];
    assign diff      = {1'b0, s.lit} - {1'b0, s.acc};

    // read port belongs to the operand fetch, otherwise to the bus
    assign mp.raddr = (s.st == st_fetch) ? s.faddr : file_index(s.araddr);

    // ==========================================================
    // next-state logic
    always_comb begin
        next_s   = s;
        mp.we    = 1'b0;
        mp.waddr = s.faddr;
        mp.wdata = rot_res;

        // watchdog ticks only while the oscillator runs
        if (s.st != st_sleep) begin
            {next_s.watchdog_counter, next_s.wd_pre} =
                16'({s.watchdog_counter, s.wd_pre} + 16'h0001);
        end

        // write address and data may arrive in either order
        if (awvalid && awready) begin
            next_s.aw_hold = 1'b1;
            next_s.awaddr  = awaddr;
        end
        if (wvalid && wready) begin
            next_s.w_hold = 1'b1;
            next_s.wdata  = wdata;
            next_s.wstrb  = wstrb;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end

        if (commit) begin
            next_s.aw_hold = 1'b0;
            next_s.w_hold  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
            if (s.awaddr[11:2] == OFF_INSTR[11:2]) begin
                if (s.wstrb[0]) begin
                    next_s.op   = launch_op;
                    next_s.dest = s.wdata[INSTR_DEST_BIT];
                end
                if (s.wstrb[1]) begin
                    next_s.faddr = s.wdata[INSTR_FADDR_LSB +: 7];
                end
                if (s.wstrb[2]) begin
                    next_s.lit = s.wdata[INSTR_LIT_LSB +: 8];
                end
            end else if (s.awaddr[11:2] == OFF_ACC[11:2]) begin
                if (s.wstrb[0]) begin
                    next_s.acc = s.wdata[7:0];
                end
            end else if (s.awaddr[11:2] == OFF_STATUS[11:2]) begin
                if (s.wstrb[0]) begin
                    next_s.carry             = s.wdata[ST_CARRY];
                    next_s.nibble_carry_flag = s.wdata[ST_NIBBLE];
                    next_s.zero              = s.wdata[ST_ZERO];
                end
            end else if (is_file(s.awaddr)) begin
                mp.we    = s.wstrb[0];
                mp.waddr = file_index(s.awaddr);
                mp.wdata = s.wdata[7:0];
            end else if (s.awaddr[11:2] != OFF_WATCHDOG[11:2]) begin
                next_s.bresp = RESP_SLVERR;
            end
        end

        // instruction sequencer
        unique case (s.st)
            st_idle: begin
                if (launch) begin
                    unique case (launch_op)
                        rotate_left_carry_op,
                        rotate_right_carry_op: next_s.st = st_fetch;
                        literal_minus_acc_op:  next_s.st = st_exec;
                        sleep_op: begin
                            next_s.st                = st_sleep;
                            next_s.power_down_flag_n = 1'b0;
                            next_s.timeout_flag_n    = 1'b1;
                            next_s.watchdog_counter  = 8'h00;
                            next_s.wd_pre            = 8'h00;
                        end
                    endcase
                end
            end
            st_fetch: next_s.st = st_exec;
            st_exec: begin
                next_s.st = st_idle;
                if (s.op == literal_minus_acc_op) begin
                    next_s.acc               = diff[7:0];
                    next_s.carry             = !diff[8];
                    next_s.nibble_carry_flag = (s.acc[3:0] <= s.lit[3:0]);
                    next_s.zero              = (diff[7:0] == 8'h00);
                end else begin
                    next_s.carry = rot_carry;
                    if (s.dest) begin
                        mp.we = 1'b1;
                    end else begin
                        next_s.acc = rot_res;
                    end
                end
            end
            // oscillator stays halted until the wake pin is high
            st_sleep: if (wake_req) next_s.st = st_idle;
        endcase

        // read pipeline: latch address, give memory a cycle, return data
        if (arvalid && arready) begin
            next_s.araddr   = araddr;
            next_s.rd_stage = RD_ADDR;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s.rd_stage == RD_ADDR && s.st != st_fetch) begin
            next_s.rd_stage = RD_DATA;
        end
        if (s.rd_stage == RD_DATA) begin
            next_s.rd_stage = RD_IDLE;
            next_s.rvalid   = 1'b1;
            next_s.rresp    = RESP_OKAY;
            next_s.rdata    = 32'h0000_0000;
            if (s.araddr[11:2] == OFF_INSTR[11:2]) begin
                next_s.rdata[INSTR_OP_LSB +: 2]    = s.op;
                next_s.rdata[INSTR_DEST_BIT]       = s.dest;
                next_s.rdata[INSTR_FADDR_LSB +: 7] = s.faddr;
                next_s.rdata[INSTR_LIT_LSB +: 8]   = s.lit;
            end else if (s.araddr[11:2] == OFF_ACC[11:2]) begin
                next_s.rdata[7:0] = s.acc;
            end else if (s.araddr[11:2] == OFF_STATUS[11:2]) begin
                next_s.rdata[ST_CARRY]     = s.carry;
                next_s.rdata[ST_NIBBLE]    = s.nibble_carry_flag;
                next_s.rdata[ST_ZERO]      = s.zero;
                next_s.rdata[ST_TIMEOUT_N] = s.timeout_flag_n;
                next_s.rdata[ST_PDOWN_N]   = s.power_down_flag_n;
                next_s.rdata[ST_SLEEP]     = (s.st == st_sleep);
                next_s.rdata[ST_BUSY]      = (s.st != st_idle);
            end else if (s.araddr[11:2] == OFF_WATCHDOG[11:2]) begin
                next_s.rdata[WD_COUNT_LSB +: 8] = s.watchdog_counter;
                next_s.rdata[WD_PRE_LSB +: 8]   = s.wd_pre;
            end else if (is_file(s.araddr)) begin
                next_s.rdata[7:0] = mp.rdata;
            end else begin
                next_s.rresp = RESP_SLVERR;
            end
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s                   <= '0;
            s.st                <= st_idle;
            s.acc               <= ACC_RESET;
            s.timeout_flag_n    <= TIMEOUT_N_RESET;
            s.power_down_flag_n <= PDOWN_N_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // assertions
    property p_rotate_left;
        (s.st == st_exec && s.op == rotate_left_carry_op && !s.dest)
            |=> (s.acc == {$past(fop[6:0]), $past(s.carry)}) && (s.carry == $past(fop[7]));
    endproperty
    a_rotate_left: assert property (p_rotate_left) else $error("left rotate wrong");
    property p_dest_file;
        (s.st == st_exec && s.op != literal_minus_acc_op && s.dest)
            |-> (mp.we && mp.waddr == s.faddr && mp.wdata == rot_res) ##1 $stable(s.acc);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("file destination wrong");
    property p_rotate_right;
        (s.st == st_exec && s.op == rotate_right_carry_op && !s.dest)
            |=> (s.acc == {$past(s.carry), $past(fop[7:1])}) && (s.carry == $past(fop[0]));
    endproperty
    a_rotate_right: assert property (p_rotate_right) else $error("right rotate wrong");
    property p_sleep_pd;
        (launch && s.st == st_idle && launch_op == sleep_op) |=> !s.power_down_flag_n;
    endproperty
    a_sleep_pd: assert property (p_sleep_pd) else $error("power-down flag not cleared");
    property p_sleep_to;
        (launch && s.st == st_idle && launch_op == sleep_op) |=> s.timeout_flag_n;
    endproperty
    a_sleep_to: assert property (p_sleep_to) else $error("time-out flag not set");
    property p_sleep_wd;
        (launch && s.st == st_idle && launch_op == sleep_op)
            |=> (s.watchdog_counter == 8'h00 && s.wd_pre == 8'h00) [*2];
    endproperty
    a_sleep_wd: assert property (p_sleep_wd) else $error("watchdog not cleared");
    property p_sleep_halt;
        (s.st == st_sleep && !wake_req) |=> (s.st == st_sleep) && !osc_run && !awready;
    endproperty
    a_sleep_halt: assert property (p_sleep_halt) else $error("left sleep without wake");
    property p_sub_result;
        (s.st == st_exec && s.op == literal_minus_acc_op)
            |=> s.acc == 8'($past(s.lit) - $past(s.acc));
    endproperty
    a_sub_result: assert property (p_sub_result) else $error("subtract result wrong");
    property p_sub_flags;
        (s.st == st_exec && s.op == literal_minus_acc_op)
            |=> (s.carry == ($past(s.acc) <= $past(s.lit)))
             && (s.nibble_carry_flag == ($past(s.acc[3:0]) <= $past(s.lit[3:0])))
             && (s.zero == (s.acc == 8'h00));
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");
    property p_one_cycle;
        (s.st == st_exec) |=> (s.st == st_idle)
            && (($past(s.op) == literal_minus_acc_op)
                || ($stable(s.zero) && $stable(s.nibble_carry_flag)));
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("exec not single cycle");

endmodule : rot_sub_sleep_exec

// *** tb/tb.sv ***
// self-checking bench for the rotate / subtract / sleep execution block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb
    import exec_pkg::*;
;

    // ==========================================================
    // signals
    logic        aclk;
    logic        aresetn;
    logic [11:0] awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        wake_req;
    logic        osc_run;
    int          fail_count;
    int          comparisons;
    integer      seed;

    rot_sub_sleep_exec rot_sub_sleep_exec_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .wake_req(wake_req), .osc_run(osc_run)
    );

    // clock, 10 ns period
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ==========================================================
    // verdict and hang guard
    task automatic summarize();
        if (fail_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // roughly twenty times the expected run length
    initial begin
        #200us;
        fail_count++;
        summarize();
    end

    // ==========================================================
    // bus master; ready is looked at mid-cycle, since it is stable until the next edge
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_ok, w_ok, hs_aw, hs_w, got;
        int n;
        aw_ok = 0; w_ok = 0; got = 0; n = 0;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        while (!(aw_ok && w_ok) && n < 1000) begin
            @(negedge aclk);
            hs_aw = awvalid && awready;
            hs_w = wvalid && wready;
            @(posedge aclk);
            if (hs_aw) begin awvalid <= 1'b0; aw_ok = 1; end
            if (hs_w) begin wvalid <= 1'b0; w_ok = 1; end
            n++;
        end
        bready <= 1'b1;
        while (!got && n < 2000) begin
            @(negedge aclk);
            got = bvalid;
            r = bresp;
            @(posedge aclk);
            n++;
        end
        bready <= 1'b0;
        if (!got) fail_count++;
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        bit hs, got;
        int n;
        hs = 0; got = 0; n = 0;
        araddr <= a; arvalid <= 1'b1;
        while (!hs && n < 1000) begin
            @(negedge aclk);
            hs = arvalid && arready;
            @(posedge aclk);
            n++;
        end
        arvalid <= 1'b0; rready <= 1'b1;
        while (!got && n < 2000) begin
            @(negedge aclk);
            got = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            n++;
        end
        rready <= 1'b0;
        if (!got) fail_count++;
    endtask : axi_read

    // polls the busy bit with a bounded count
    task automatic idle_wait();
        logic [31:0] v;
        logic [1:0]  r;
        int n;
        n = 0;
        v = 32'hffffffff;
        while (v[ST_BUSY] !== 1'b0 && n < 50) begin
            axi_read(OFF_STATUS, v, r);
            n++;
        end
        if (n >= 50) fail_count++;
    endtask : idle_wait

    // ==========================================================
    // main sequence with integer reference model
    initial begin
        int m_acc, m_c, m_nc, m_z, res, idx, fv, av, fl, op, dest, lit, n;
        int m_mem[128];
        logic [31:0] v;
        logic [1:0]  r;
        seed = 32'hff6fbb73;
        fail_count = 0; comparisons = 0;
        aresetn = 1'b0; awaddr = 12'h0; awvalid = 1'b0; wdata = 32'h0; wvalid = 1'b0;
        bready = 1'b0; araddr = 12'h0; arvalid = 1'b0; rready = 1'b0; wake_req = 1'b0;
        foreach (m_mem[k]) m_mem[k] = 0;
        m_acc = 0; m_c = 0; m_nc = 0; m_z = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // reset values: flags clear, both active-low status bits high
        axi_read(OFF_STATUS, v, r);
        `CHK(v[6:0], 7'h18)
        // unmapped place answers with an error and zero data
        axi_write(12'h010, 32'h5a, r);
        `CHK(r, RESP_SLVERR)
        axi_read(12'h010, v, r);
        `CHK({r, v}, {RESP_SLVERR, 32'h0})
        // random rotates and subtracts, first one a boundary with equal operands
        for (int i = 0; i < 40; i++) begin
            idx = $random(seed) & 127; fv = $random(seed) & 255; av = $random(seed) & 255;
            fl = $random(seed) & 7; op = ($random(seed) & 32'h7fffffff) % 3;
            dest = $random(seed) & 1; lit = $random(seed) & 255;
            if (i == 0) begin av = lit; op = 2; end
            if (i == 1) idx = 127;
            axi_write(OFF_FILE_BASE + 12'(idx * 4), 32'(fv), r);
            axi_write(OFF_ACC, 32'(av), r);
            axi_write(OFF_STATUS, 32'(fl), r);
            m_mem[idx] = fv; m_acc = av; m_c = fl & 1; m_nc = (fl >> 1) & 1; m_z = fl >> 2;
            axi_write(OFF_INSTR, {8'h0, 8'(lit), 1'b0, 7'(idx), 5'h0, 1'(dest), 2'(op)}, r);
            `CHK(r, RESP_OKAY)
            if (op == 0) begin
                res = ((fv << 1) | m_c) & 255; m_c = fv >> 7;
            end else if (op == 1) begin
                res = (fv >> 1) | (m_c << 7); m_c = fv & 1;
            end else begin
                res = (lit - av) & 255; m_c = (av <= lit);
                m_nc = ((av & 15) <= (lit & 15)); m_z = (res == 0);
            end
            if (op < 2 && dest == 1) m_mem[idx] = res;
            else m_acc = res;
            idle_wait();
            axi_read(OFF_ACC, v, r);
            `CHK(v[7:0], 8'(m_acc))
            axi_read(OFF_STATUS, v, r);
            `CHK(v[2:0], 3'(m_z * 4 + m_nc * 2 + m_c))
            axi_read(OFF_FILE_BASE + 12'(idx * 4), v, r);
            `CHK(v[7:0], 8'(m_mem[idx]))
        end
        // sleep: oscillator, flags, watchdog, then wake-up
        axi_write(OFF_INSTR, 32'h3, r);
        repeat (2) @(posedge aclk);
        // look mid-cycle, away from the edge that updates the outputs
        @(negedge aclk);
        `CHK(osc_run, 1'b0)
        `CHK(awready, 1'b0)
        @(posedge aclk);
        axi_read(OFF_STATUS, v, r);
        `CHK(v[5:3], 3'b101)
        axi_read(OFF_WATCHDOG, v, r);
        `CHK(v[15:0], 16'h0)
        wake_req <= 1'b1;
        n = 0;
        while (osc_run !== 1'b1 && n < 20) begin
            @(negedge aclk);
            n++;
        end
        `CHK(osc_run, 1'b1)
        @(posedge aclk);
        wake_req <= 1'b0;
        repeat (4) @(posedge aclk);
        summarize();
    end
endmodule : tb
